// file: core/tcc_timer.sv
// Eight channel capture and compare timer with pulse accumulator
//
// How it works
// - Direction bit clear: active pin edge copies counter into time register.
// - Capture sets the channel flag; channel enable gates its request.
// - Compare match sets flag and drives pin unless pin is disconnected.
// - Mode and level pick set, clear or toggle; both zero do nothing.
// - Force bit performs compare pin action now, without setting flag.
// - Channel 7 event overrides other compares through mask and data.
// - Channel 7 match resets counter when reset enable set.
// - In reset mode counter runs zero to channel 7 value, top lasts once.
// - Port writes to compare pins go to a latch shown in GPIO mode.
// - Forced compare preloads the internal output while pin disconnected.
// - Clearing disconnect connects the preloaded output without glitches.
// - Accumulator is 16 bits, mode chosen by gate select.
// - Event mode counts edges of chosen polarity on the channel 7 pin.
// - Accumulator wrap from all ones sets overflow flag; enable gates it.
// - Event counting continues while the timer is disabled.
// - Gated mode counts a divide-by-64 clock while input level active.
// - Trailing edge of active level sets input flag; enable gates it.
// - Divide-by-64 clock comes from prescaler and stops when timer off.
// - Active-high requests per channel, accumulator in/ovf, counter wrap.
// - Prescale by power of two up to 128, or fine value plus one.
// - Disconnected pin keeps state on compare but flag still sets.
//
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module tcc_timer
  import tcc_pkg::*;
#(
  parameter int NCH = N_CH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Channel pins
  input wire logic [NCH-1:0] ch_pin_in,
  output logic [NCH-1:0] ch_pin_out,
  output logic [NCH-1:0] ch_pin_oe,
  // Interrupt requests
  output logic [NCH-1:0] channel_irq,
  output logic accum_input_irq,
  output logic accum_overflow_irq,
  output logic counter_wrap_irq
);
  // ==================================================
  // Registers
  bus_req_t req;
  logic ack_q;
  logic [NCH-1:0] channel_direction_select_q;
  logic [NCH-1:0] overflow_toggle_enable_q;
  logic [NCH-1:0] output_mode_bit_q;
  logic [NCH-1:0] output_level_bit_q;
  logic [NCH-1:0] channel_int_enable_q;
  logic [NCH-1:0] channel_event_flag_q;
  logic [NCH-1:0] channel7_override_mask_q;
  logic [NCH-1:0] ch7_data_q;
  logic [NCH-1:0] pin_disconnect_bit_q;
  logic [NCH-1:0] port_latch_q;
  logic [NCH-1:0] out_reg_q;
  logic [NCH-1:0] pin_s1_q;
  logic [NCH-1:0] pin_s2_q;
  logic [NCH-1:0] pin_s3_q;
  logic [2*NCH-1:0] edge_sel_q;
  logic [15:0] channel_time_register_q [NCH];
  logic [15:0] free_running_counter_q;
  logic timer_enable_q;
  logic fine_divider_enable_q;
  logic [2:0] bus_clock_divider_select_q;
  logic [7:0] fine_divider_value_q;
  logic wrap_int_enable_q;
  logic counter_reset_enable_q;
  logic counter_wrap_flag_q;
  logic accum_enable_q;
  logic accum_gate_select_q;
  logic accum_polarity_select_q;
  logic accum_overflow_int_enable_q;
  logic accum_input_int_enable_q;
  logic accum_overflow_flag_q;
  logic accum_input_flag_q;
  logic [15:0] accum_count_q;

  // ==================================================
  // Bus decode
  logic wr;
  logic rd;
  logic flag_clear_ok;
  logic is_time;
  logic [2:0] time_idx;
  logic [31:0] wdata;
  logic [31:0] rdata;

  assign req = '{read: avs_read, write: avs_write, address: avs_address,
                 writedata: avs_writedata};
  // One wait cycle on every access, so read data is registered
  assign avs_waitrequest = (req.read || req.write) && !ack_q;
  assign wr = req.write && ack_q;
  assign rd = req.read && !ack_q;
  assign wdata = req.writedata & {{8{avs_byteenable[3]}},
    {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign flag_clear_ok = timer_enable_q || accum_enable_q;
  assign is_time = (req.address[7:5] == REG_TIME0[7:5]);
  assign time_idx = req.address[4:2];

  // ==================================================
  // Prescaler
  logic count_tick;
  logic gate_tick;
  tcc_prescaler u_prescaler (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(timer_enable_q),
    .fine_divider_enable(fine_divider_enable_q),
    .bus_clock_divider_select(bus_clock_divider_select_q),
    .fine_divider_value(fine_divider_value_q),
    .count_tick(count_tick),
    .gate_tick(gate_tick)
  );

  // ==================================================
  // Pin edge detection after two-flop synchroniser
  logic [NCH-1:0] rise;
  logic [NCH-1:0] fall;
  logic [NCH-1:0] cap_edge;
  assign rise = pin_s2_q & ~pin_s3_q;
  assign fall = ~pin_s2_q & pin_s3_q;
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      unique case (edge_sel_q[2*i +: 2])
        2'b01: cap_edge[i] = rise[i];
        2'b10: cap_edge[i] = fall[i];
        2'b11: cap_edge[i] = rise[i] | fall[i];
        default: cap_edge[i] = 1'b0;
      endcase
    end
  end
  logic [NCH-1:0] capture;
  // Capture needs a running timer; pulses shorter than one clock may vanish
  assign capture = cap_edge & ~channel_direction_select_q
                   & {NCH{timer_enable_q}};

  // ==================================================
  // Compare and counter
  logic [NCH-1:0] match;
  logic [NCH-1:0] force_hit;
  logic ch7_event;
  logic top_reset;
  logic cnt_wrap;
  logic [15:0] cnt_d;
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      match[i] = count_tick && channel_direction_select_q[i] &&
                 (free_running_counter_q == channel_time_register_q[i]);
    end
  end
  assign force_hit = (wr && req.address == REG_FORCE) ?
                     wdata[NCH-1:0] & channel_direction_select_q &
                     {NCH{timer_enable_q}} : '0;
  assign top_reset = counter_reset_enable_q && match[NCH-1];
  assign cnt_wrap = count_tick && !top_reset &&
                    free_running_counter_q == ALL_ONES;
  assign ch7_event = match[NCH-1] || force_hit[NCH-1] ||
                     (cnt_wrap && overflow_toggle_enable_q[NCH-1]);
  // Top value lasts one prescaled period, then the tick drops it to zero
  assign cnt_d = top_reset ? RST_WORD : free_running_counter_q + 16'h0001;

  // Next internal output state per channel
  logic [NCH-1:0] out_d;
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      out_d[i] = out_reg_q[i];
      if (match[i] || force_hit[i])
        out_d[i] = apply_action(out_reg_q[i],
          {output_mode_bit_q[i], output_level_bit_q[i]});
      if (ch7_event && channel7_override_mask_q[i])
        out_d[i] = ch7_data_q[i];
    end
  end

  // Timer owns a pin when it compares, is not disconnected and mode/level or mask is non-zero
  logic [NCH-1:0] tim_owns;
  assign tim_owns = channel_direction_select_q &
                    (output_mode_bit_q | output_level_bit_q |
                     channel7_override_mask_q) & ~pin_disconnect_bit_q;
  assign ch_pin_out = (tim_owns & out_reg_q) |
                      (~tim_owns & port_latch_q);
  assign ch_pin_oe = tim_owns | channel_direction_select_q;

  // ==================================================
  // Pulse accumulator
  logic acc_level;
  logic acc_level_prev;
  logic acc_active;
  logic acc_step;
  logic acc_trail;
  assign acc_level = pin_s2_q[NCH-1] ^ ~accum_polarity_select_q;
  assign acc_level_prev = pin_s3_q[NCH-1] ^ ~accum_polarity_select_q;
  assign acc_active = accum_polarity_select_q ? rise[NCH-1] : fall[NCH-1];
  assign acc_trail = accum_enable_q && accum_gate_select_q &&
                     acc_level_prev && !acc_level;
  assign acc_step = accum_enable_q && (accum_gate_select_q ?
                    (gate_tick && acc_level) : acc_active);

  // ==================================================
  // Read mux
  always_comb begin
    rdata = UNMAPPED_DATA;
    if (is_time)
      rdata = {16'h0000, channel_time_register_q[time_idx]};
    else begin
      unique case (req.address)
        REG_DIR: rdata[NCH-1:0] = channel_direction_select_q;
        REG_COUNT: rdata[15:0] = free_running_counter_q;
        REG_SYS: rdata[7:0] = {timer_enable_q, 3'b000,
                               fine_divider_enable_q, 3'b000};
        REG_OVTOG: rdata[NCH-1:0] = overflow_toggle_enable_q;
        REG_OUTCTL: rdata[2*NCH-1:0] = {output_mode_bit_q,
                                        output_level_bit_q};
        REG_EDGE: rdata[2*NCH-1:0] = edge_sel_q;
        REG_INTEN: rdata[NCH-1:0] = channel_int_enable_q;
        REG_DIV: rdata[7:0] = {wrap_int_enable_q, 3'b000,
                               counter_reset_enable_q,
                               bus_clock_divider_select_q};
        REG_FLAG1: rdata[NCH-1:0] = channel_event_flag_q;
        REG_FLAG2: rdata[7] = counter_wrap_flag_q;
        REG_MASK7: rdata[NCH-1:0] = channel7_override_mask_q;
        REG_DATA7: rdata[NCH-1:0] = ch7_data_q;
        REG_ACTL: rdata[7:0] = {1'b0, accum_enable_q, accum_gate_select_q,
          accum_polarity_select_q, 2'b00, accum_overflow_int_enable_q,
          accum_input_int_enable_q};
        REG_AFLAG: rdata[1:0] = {accum_overflow_flag_q, accum_input_flag_q};
        REG_ACNT: rdata[15:0] = accum_count_q;
        REG_DISC: rdata[NCH-1:0] = pin_disconnect_bit_q;
        REG_FINE: rdata[7:0] = fine_divider_value_q;
        REG_PORT: rdata[NCH-1:0] = port_latch_q;
        default: rdata = UNMAPPED_DATA;
      endcase
    end
  end

  // ==================================================
  // Flag next values; a hardware set wins over a software clear
  logic [NCH-1:0] ch_clr;
  logic [NCH-1:0] ch_flag_d;
  assign ch_clr = (wr && req.address == REG_FLAG1 && flag_clear_ok) ?
                  wdata[NCH-1:0] : '0;
  assign ch_flag_d = (channel_event_flag_q & ~ch_clr) | capture |
                     match;
  logic wrap_clr;
  logic aov_clr;
  logic ain_clr;
  assign wrap_clr = wr && req.address == REG_FLAG2 && flag_clear_ok &&
                    wdata[7];
  assign aov_clr = wr && req.address == REG_AFLAG && flag_clear_ok &&
                   wdata[AFLAG_OV];
  assign ain_clr = wr && req.address == REG_AFLAG && flag_clear_ok &&
                   wdata[AFLAG_IN];
  logic acc_ovf;
  assign acc_ovf = acc_step && accum_count_q == ALL_ONES;
  logic ain_set;
  assign ain_set = accum_gate_select_q ? acc_trail : acc_step;

  // ==================================================
  // Interrupt requests
  assign channel_irq = channel_event_flag_q & channel_int_enable_q;
  assign accum_input_irq = accum_input_flag_q &&
                           accum_input_int_enable_q;
  assign accum_overflow_irq = accum_overflow_flag_q &&
                              accum_overflow_int_enable_q;
  assign counter_wrap_irq = counter_wrap_flag_q && wrap_int_enable_q;

  // ==================================================
  // Sequential state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      avs_readdata <= UNMAPPED_DATA;
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
      out_reg_q <= '0;
      channel_event_flag_q <= '0;
      free_running_counter_q <= RST_WORD;
      counter_wrap_flag_q <= 1'b0;
      accum_count_q <= RST_WORD;
      accum_overflow_flag_q <= 1'b0;
      accum_input_flag_q <= 1'b0;
    end else begin
      ack_q <= (req.read || req.write) && !ack_q;
      if (rd)
        avs_readdata <= rdata;
      pin_s1_q <= ch_pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      out_reg_q <= out_d;
      channel_event_flag_q <= ch_flag_d;
      if (wr && req.address == REG_COUNT)
        free_running_counter_q <= wdata[15:0];
      else if (count_tick)
        free_running_counter_q <= cnt_d;
      counter_wrap_flag_q <= cnt_wrap || (counter_wrap_flag_q && !wrap_clr);
      if (wr && req.address == REG_ACNT)
        accum_count_q <= wdata[15:0];
      else if (acc_step)
        accum_count_q <= accum_count_q + 16'h0001;
      accum_overflow_flag_q <= acc_ovf ||
                               (accum_overflow_flag_q && !aov_clr);
      accum_input_flag_q <= ain_set || (accum_input_flag_q && !ain_clr);
    end
  end

  // Plain configuration registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_direction_select_q <= '0;
      overflow_toggle_enable_q <= '0;
      output_mode_bit_q <= '0;
      output_level_bit_q <= '0;
      edge_sel_q <= '0;
      channel_int_enable_q <= '0;
      channel7_override_mask_q <= '0;
      ch7_data_q <= '0;
      pin_disconnect_bit_q <= '0;
      port_latch_q <= '0;
      timer_enable_q <= 1'b0;
      fine_divider_enable_q <= 1'b0;
      bus_clock_divider_select_q <= 3'b000;
      fine_divider_value_q <= 8'h00;
      wrap_int_enable_q <= 1'b0;
      counter_reset_enable_q <= 1'b0;
      accum_enable_q <= 1'b0;
      accum_gate_select_q <= 1'b0;
      accum_polarity_select_q <= 1'b0;
      accum_overflow_int_enable_q <= 1'b0;
      accum_input_int_enable_q <= 1'b0;
    end else if (wr) begin
      unique case (req.address)
        REG_DIR: channel_direction_select_q <= wdata[NCH-1:0];
        REG_SYS: begin
          timer_enable_q <= wdata[SYS_TEN];
          fine_divider_enable_q <= wdata[SYS_FINE];
        end
        REG_OVTOG: overflow_toggle_enable_q <= wdata[NCH-1:0];
        REG_OUTCTL: begin
          output_mode_bit_q <= wdata[2*NCH-1:NCH];
          output_level_bit_q <= wdata[NCH-1:0];
        end
        REG_EDGE: edge_sel_q <= wdata[2*NCH-1:0];
        REG_INTEN: channel_int_enable_q <= wdata[NCH-1:0];
        REG_DIV: begin
          wrap_int_enable_q <= wdata[DIV_WRAP_IE];
          counter_reset_enable_q <= wdata[3];
          bus_clock_divider_select_q <= wdata[2:0];
        end
        REG_MASK7: channel7_override_mask_q <= wdata[NCH-1:0];
        REG_DATA7: ch7_data_q <= wdata[NCH-1:0];
        REG_ACTL: begin
          accum_enable_q <= wdata[ACTL_EN];
          accum_gate_select_q <= wdata[ACTL_GATE];
          accum_polarity_select_q <= wdata[ACTL_POL];
          accum_overflow_int_enable_q <= wdata[ACTL_OVIE];
          accum_input_int_enable_q <= wdata[ACTL_INIE];
        end
        REG_DISC: pin_disconnect_bit_q <= wdata[NCH-1:0];
        REG_FINE: fine_divider_value_q <= wdata[7:0];
        REG_PORT: port_latch_q <= wdata[NCH-1:0];
        default: ;
      endcase
    end
  end

  // Channel time registers; capture wins over a software write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NCH; i++)
        channel_time_register_q[i] <= RST_WORD;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (capture[i])
          channel_time_register_q[i] <= free_running_counter_q;
        else if (wr && is_time && time_idx == 3'(i))
          channel_time_register_q[i] <= wdata[15:0];
      end
    end
  end
endmodule : tcc_timer

// file: pkg/tcc_pkg.sv
// Package with register map, field layouts and reset values of the timer
package tcc_pkg;
  localparam int N_CH = 8;
  // ====================================================
  // Register word offsets (byte addresses, one word each)
  localparam logic [7:0] REG_DIR = 8'h00;
  localparam logic [7:0] REG_FORCE = 8'h04;
  localparam logic [7:0] REG_COUNT = 8'h08;
  localparam logic [7:0] REG_SYS = 8'h0c;
  localparam logic [7:0] REG_OVTOG = 8'h10;
  localparam logic [7:0] REG_OUTCTL = 8'h14;
  localparam logic [7:0] REG_EDGE = 8'h18;
  localparam logic [7:0] REG_INTEN = 8'h1c;
  localparam logic [7:0] REG_DIV = 8'h20;
  localparam logic [7:0] REG_FLAG1 = 8'h24;
  localparam logic [7:0] REG_FLAG2 = 8'h28;
  localparam logic [7:0] REG_MASK7 = 8'h2c;
  localparam logic [7:0] REG_DATA7 = 8'h30;
  localparam logic [7:0] REG_ACTL = 8'h34;
  localparam logic [7:0] REG_AFLAG = 8'h38;
  localparam logic [7:0] REG_ACNT = 8'h3c;
  localparam logic [7:0] REG_DISC = 8'h40;
  localparam logic [7:0] REG_FINE = 8'h44;
  localparam logic [7:0] REG_PORT = 8'h48;
  localparam logic [7:0] REG_TIME0 = 8'h80;
  // ====================================================
  // Field positions
  localparam int SYS_TEN = 7;
  localparam int SYS_FINE = 3;
  localparam int DIV_WRAP_IE = 7;
  localparam int ACTL_EN = 6;
  localparam int ACTL_GATE = 5;
  localparam int ACTL_POL = 4;
  localparam int ACTL_OVIE = 1;
  localparam int ACTL_INIE = 0;
  localparam int AFLAG_OV = 1;
  localparam int AFLAG_IN = 0;
  // ====================================================
  // Reset values and counts
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] ALL_ONES = 16'hffff;
  localparam int GATE_DIV = 64;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  typedef enum logic [1:0] {
    PIN_NONE = 2'b00,
    PIN_TOGGLE = 2'b01,
    PIN_CLEAR = 2'b10,
    PIN_SET = 2'b11
  } pin_action_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } bus_req_t;

  function automatic logic apply_action(input logic cur,
                                        input logic [1:0] act);
    unique case (act)
      PIN_TOGGLE: apply_action = ~cur;
      PIN_CLEAR: apply_action = 1'b0;
      PIN_SET: apply_action = 1'b1;
      default: apply_action = cur;
    endcase
  endfunction : apply_action
endpackage : tcc_pkg

// file: core/tcc_prescaler.sv
// Counter clock prescaler with coarse and fine divide selection
`timescale 1ns/1ps
module tcc_prescaler
  import tcc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic fine_divider_enable,
  input wire logic [2:0] bus_clock_divider_select,
  input wire logic [7:0] fine_divider_value,
  // Ticks
  output logic count_tick,
  output logic gate_tick
);
  logic [7:0] stage_q;
  logic [7:0] stage_d;
  logic [7:0] limit;
  logic [5:0] g64_q;
  logic [5:0] g64_d;
  logic wrap;

  // Limit compared every cycle, so a lowered divider wraps at once on the >= test
  assign limit = fine_divider_enable ? fine_divider_value :
                 8'((9'h001 << bus_clock_divider_select) - 9'h001);
  assign wrap = run && (stage_q >= limit);
  assign stage_d = !run ? 8'h00 : (wrap ? 8'h00 : stage_q + 8'h01);
  assign g64_d = wrap ? g64_q + 6'h01 : g64_q;
  assign count_tick = wrap;
  // Gated clock only exists while the prescaler runs
  assign gate_tick = wrap && (g64_q == 6'(GATE_DIV - 1));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_q <= 8'h00;
      g64_q <= 6'h00;
    end else begin
      stage_q <= stage_d;
      g64_q <= g64_d;
    end
  end
endmodule : tcc_prescaler

// file: dv/tcc_timer_monitor.sv
// Bus handshake and interrupt request checker for the timer
`timescale 1ns/1ps
module tcc_timer_monitor #(
  parameter int NCH = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Requests
  input wire logic [NCH-1:0] channel_irq,
  input wire logic accum_input_irq,
  input wire logic accum_overflow_irq,
  input wire logic counter_wrap_irq
);
  // ====================================================
  // Helpers
  wire req = avs_read | avs_write;
  wire took_w = avs_write & ~avs_waitrequest;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ====================================================
  // Handshake
  a_one_wait: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait state longer than one cycle");
  a_first_wait: assert property (req && !$past(req) |-> avs_waitrequest)
    else $error("new request answered without wait state");
  a_idle_ready: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest high while idle");
  a_rdata_hold: assert property ($changed(avs_readdata)
    |-> $past(avs_read && avs_waitrequest))
    else $error("read data moved without a read");
  // ====================================================
  // Requests only drop after software writes a flag or enable
  a_chan_irq_fall: assert property (
    |($past(channel_irq) & ~channel_irq) |-> $past(took_w))
    else $error("channel request dropped by itself");
  a_ain_irq_fall: assert property (
    $fell(accum_input_irq) |-> $past(took_w))
    else $error("accumulator input request dropped by itself");
  a_aov_irq_fall: assert property (
    $fell(accum_overflow_irq) |-> $past(took_w))
    else $error("accumulator overflow request dropped by itself");
  a_wrap_irq_fall: assert property (
    $fell(counter_wrap_irq) |-> $past(took_w))
    else $error("counter wrap request dropped by itself");
endmodule : tcc_timer_monitor

bind tcc_timer tcc_timer_monitor #(.NCH(NCH)) u_tcc_timer_monitor (
  .core_clk(core_clk), .rst_n(rst_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .channel_irq(channel_irq),
  .accum_input_irq(accum_input_irq),
  .accum_overflow_irq(accum_overflow_irq),
  .counter_wrap_irq(counter_wrap_irq)
);

// file: dv/tcc_pin_model.sv
// External signal source on the timer channel pins
`timescale 1ns/1ps
module tcc_pin_model (
  // Clock
  input wire logic core_clk,
  // Wanted levels and timer side of the pins
  input wire logic [7:0] level,
  input wire logic [7:0] ch_pin_out,
  input wire logic [7:0] ch_pin_oe,
  // Pin levels seen by the timer
  output logic [7:0] ch_pin_in
);
  logic [7:0] drv_q;
  logic [2:0] hold_q;
  initial drv_q = 8'h00;
  initial hold_q = 3'h0;
  // Each level lasts at least four clocks, so no pulse is too short
  always @(posedge core_clk) begin
    if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
    else if (level != drv_q) begin
      drv_q <= level;
      hold_q <= 3'h4;
    end
  end
  // A driven pin shows the timer's level
  assign ch_pin_in = (ch_pin_oe & ch_pin_out) | (~ch_pin_oe & drv_q);
endmodule : tcc_pin_model

// file: dv/test_tcc_timer.sv
// Self-checking bench for the capture, compare and accumulator timer
`timescale 1ns/1ps
module test_tcc_timer import tcc_pkg::*;;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd, c;
  logic avs_waitrequest, accum_input_irq, accum_overflow_irq;
  logic counter_wrap_irq;
  logic [7:0] ch_pin_in, ch_pin_out, ch_pin_oe, channel_irq;
  logic [7:0] level = 8'h00;
  wire [10:0] irqs = {counter_wrap_irq, accum_overflow_irq,
    accum_input_irq, channel_irq};
  int bad_count = 0;
  int n_tests = 0;
  always #5 core_clk = ~core_clk;
  tcc_timer u_tcc_timer (.core_clk(core_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ch_pin_in(ch_pin_in),
    .ch_pin_out(ch_pin_out), .ch_pin_oe(ch_pin_oe),
    .channel_irq(channel_irq), .accum_input_irq(accum_input_irq),
    .accum_overflow_irq(accum_overflow_irq),
    .counter_wrap_irq(counter_wrap_irq));
  tcc_pin_model u_tcc_pin_model (.core_clk(core_clk), .level(level),
    .ch_pin_out(ch_pin_out), .ch_pin_oe(ch_pin_oe),
    .ch_pin_in(ch_pin_in));
  // ====================================================
  // Shared tasks
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic check(input string what, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, s);
    end
  endtask : check
  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d = 32'h0);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    if (n >= 20) bad_count++;
    if (n >= 20) wrap_up();
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask : bus
  task automatic wait_irq(input int b);
    int n;
    for (n = 0; n < 300 && irqs[b] !== 1'b1; n++) @(posedge core_clk);
    if (n >= 300) bad_count++;
    if (n >= 300) wrap_up();
  endtask : wait_irq
  task automatic arm(input logic [7:0] a);
    bus(0, REG_COUNT);
    bus(1, a, {16'h0, rd[15:0] + 16'h28});
  endtask : arm
  task automatic pulse(input int n);
    level[7] <= 1'b1;
    repeat (n) @(posedge core_clk);
    level[7] <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask : pulse
  // ====================================================
  // Scenarios
  task automatic t_regs;
    bus(0, REG_DIV);
    check("div reset", rd, {16'h0, RST_WORD});
    bus(1, 8'hfc, 32'h5a);
    bus(0, 8'hfc);
    check("unmapped", rd, UNMAPPED_DATA);
    $display("regs done");
  endtask : t_regs
  task automatic t_capture;
    bus(1, REG_EDGE, 32'h1);
    bus(1, REG_INTEN, 32'h3);
    bus(1, REG_SYS, 32'h80);
    bus(0, REG_COUNT);
    c = rd;
    level[0] <= 1'b1;
    wait_irq(0);
    bus(0, REG_TIME0);
    check("capture", (rd[15:0] - c[15:0]) < 16'd30, 1'b1);
    bus(1, REG_SYS, 32'h0);
    bus(1, REG_FLAG1, 32'h1);
    check("clear off", channel_irq[0], 1'b1);
    bus(1, REG_SYS, 32'h80);
    bus(1, REG_FLAG1, 32'h1);
    check("clear on", channel_irq[0], 1'b0);
    $display("capture done");
  endtask : t_capture
  task automatic t_compare;
    logic [15:0] ctl [4] = '{16'h0202, 16'h0200, 16'h0002, 16'h0000};
    logic [3:0] want = 4'b1010;
    bus(1, REG_DIR, 32'h2);
    for (int i = 0; i < 4; i++) begin
      bus(1, REG_OUTCTL, {16'h0, ctl[i]});
      bus(1, REG_FORCE, 32'h2);
      check("force pin", ch_pin_out[1], want[3-i]);
      check("force flag", channel_irq[1], 1'b0);
      bus(1, REG_PORT, 32'h0);
      check("port latch", ch_pin_out[1], want[3-i]);
    end
    bus(1, REG_OUTCTL, 32'h2);
    arm(REG_TIME0 + 8'h04);
    wait_irq(1);
    check("match toggle", ch_pin_out[1], 1'b0);
    bus(1, REG_FLAG1, 32'h2);
    bus(1, REG_DISC, 32'h2);
    bus(1, REG_PORT, 32'h0);
    arm(REG_TIME0 + 8'h04);
    wait_irq(1);
    check("disc pin", ch_pin_out[1], 1'b0);
    bus(1, REG_OUTCTL, 32'h0200);
    bus(1, REG_PORT, 32'h2);
    bus(1, REG_FORCE, 32'h2);
    bus(1, REG_DISC, 32'h0);
    check("preload", ch_pin_out[1], 1'b0);
    $display("compare done");
  endtask : t_compare
  task automatic t_counter;
    bus(1, REG_DIV, 32'h80);
    bus(1, REG_COUNT, 32'hfff0);
    wait_irq(10);
    bus(1, REG_FLAG2, 32'h80);
    check("wrap clear", counter_wrap_irq, 1'b0);
    bus(1, REG_DIR, 32'h82);
    bus(1, REG_TIME0 + 8'h1c, 32'h20);
    bus(1, REG_MASK7, 32'h2);
    bus(1, REG_DATA7, 32'h2);
    bus(1, REG_DIV, 32'h08);
    repeat (12) begin
      bus(0, REG_COUNT);
      check("modulus", rd <= 32'h20, 1'b1);
    end
    check("ch7 ovr", ch_pin_out[1], 1'b1);
    bus(1, REG_DIV, 32'h0);
    bus(1, REG_DIR, 32'h0);
    $display("counter done");
  endtask : t_counter
  task automatic t_accum;
    bus(1, REG_OUTCTL, 32'h0);
    bus(1, REG_MASK7, 32'h0);
    bus(1, REG_SYS, 32'h0);
    bus(1, REG_ACTL, 32'h53);
    bus(1, REG_ACNT, 32'hfffe);
    pulse(6);
    pulse(6);
    bus(0, REG_ACNT);
    check("events", rd, 32'h0);
    check("ovf irq", accum_overflow_irq, 1'b1);
    bus(1, REG_AFLAG, 32'h3);
    check("ovf clear", accum_overflow_irq, 1'b0);
    bus(1, REG_SYS, 32'h80);
    bus(1, REG_ACTL, 32'h73);
    bus(1, REG_ACNT, 32'h0);
    pulse(200);
    bus(0, REG_ACNT);
    check("gated", rd >= 32'h2 && rd <= 32'h4, 1'b1);
    check("trail flag", accum_input_irq, 1'b1);
    bus(1, REG_AFLAG, 32'h3);
    bus(1, REG_SYS, 32'h0);
    pulse(200);
    bus(0, REG_ACNT);
    check("gate off", rd >= 32'h2 && rd <= 32'h4, 1'b1);
    $display("accum done");
  endtask : t_accum
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_capture();
    t_compare();
    t_counter();
    t_accum();
    wrap_up();
  end
endmodule : test_tcc_timer
